// [shared/esp_defines.svh]
// constants for the serial memory slave front end
`ifndef ESP_DEFINES_SVH
`define ESP_DEFINES_SVH

// select value used when the chip-select pins are not bonded out
`define ESP_FIXED_CS 3'h1
// bit counter positions inside one nine-slot byte frame
`define ESP_LAST_DATA_BIT 4'h7
`define ESP_ACK_SLOT 4'h8
// a stop's own clock rise counts as the first bit after the acknowledge
`define ESP_STOP_SLOT 4'h1
// read/write flag value that requests a read
`define ESP_RW_READ 1'b1
// write buffer shape: id-page flag plus one data byte
`define ESP_FIFO_WIDTH 9
`define ESP_FIFO_DEPTH 8
// identification page is 32 bytes, so only five address bits count
`define ESP_ID_ADDR_MASK 16'h001f
// number of pin bits brought into the system clock
`define ESP_SYNC_WIDTH 7

`endif

// [shared/esp_pkg.sv]
// types shared by the serial memory slave front end
`default_nettype none
package esp_pkg;

  // protocol engine states
  typedef enum logic [2:0] {
    ESP_ST_IDLE = 3'h0,
    ESP_ST_SEL = 3'h1,
    ESP_ST_ADDR_HI = 3'h2,
    ESP_ST_ADDR_LO = 3'h3,
    ESP_ST_DATA = 3'h4,
    ESP_ST_READ = 3'h5,
    ESP_ST_IGNORE = 3'h6
  } esp_state_type;

endpackage
`default_nettype wire

// [core/esp_sync.sv]
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
`default_nettype none
module esp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    meta <= d_in;
    q_out <= meta;
  end

endmodule
`default_nettype wire

// [core/esp_fifo.sv]
// write data buffer with registered output stage
`timescale 1ns/100ps
`default_nettype none
module esp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic load;

  // depth must be a power of two so the pointers wrap on their own
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign push = in_valid_in && in_ready_out;
  assign load = (count != '0) && (!out_valid_out || out_ready_in);

  // storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wptr] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (load) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // output register keeps the drain side glitch free
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (load) begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rptr];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [core/esp_slave.sv]
// two-wire memory slave front end: select, address, protect, power reset
`timescale 1ns/100ps
`default_nettype none
`include "esp_defines.svh"
module esp_slave #(
  parameter logic [3:0] MEM_TYPE_ID = 4'h3, // arbitrary value
  parameter logic [3:0] ID_TYPE_ID = 4'h4, // arbitrary value
  parameter bit CS_PINS_PRESENT = 1'b1,
  parameter logic [2:0] CS_PIN_USED = 3'h7,
  parameter bit WP_PIN_USED = 1'b1,
  parameter bit HAS_ID_PAGE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic chip_select_bit2_in,
  input wire logic chip_select_bit1_in,
  input wire logic chip_select_bit0_in,
  input wire logic write_protect_input_in,
  input wire logic por_ok_in,
  input wire logic write_busy_in,
  input wire logic id_locked_in,
  input wire logic [7:0] rd_data_in,
  output logic rd_next_out,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic [7:0] wr_data_out,
  output logic wr_id_page_out,
  output logic [15:0] addr_out,
  output logic write_start_out,
  output logic standby_out
);

  // link side: data bit sampled on the master's clock
  logic link_bit;

  // system side synchronised pins
  logic [`ESP_SYNC_WIDTH-1:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic por_s;
  logic [2:0] cs_s;
  logic scl_d;
  logic sda_d;

  // protocol engine
  esp_pkg::esp_state_type state;
  esp_pkg::esp_state_type after_state;
  esp_pkg::esp_state_type next_after;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic ack_drive;
  logic next_ack;
  logic data_acked;
  logic id_sel;

  logic sys_rst;
  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic bit_ev;
  logic active;
  logic [7:0] rx_byte;
  logic [2:0] cs_expect;
  logic wp_eff;
  logic byte_done;
  logic ack_slot;
  logic push;
  logic fifo_ready;
  logic [`ESP_FIFO_WIDTH-1:0] fifo_out;

  // select byte check: type field and chip-select field
  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] cs);
    logic type_ok;
    type_ok = (b[7:4] == MEM_TYPE_ID) || (HAS_ID_PAGE && (b[7:4] == ID_TYPE_ID));
    sel_match = type_ok && (b[3:1] == cs);
  endfunction

  // sample the data line on each rising serial clock; no reset is needed,
  // as the system side reads it only after it has seen that same edge, and
  // so the master never has to clock an idle bus to clear the link side
  always_ff @(posedge scl_in) begin
    link_bit <= sda_in;
  end

  // pins cross into the system clock; link_bit is stable for a whole
  // serial clock period after the rising edge that loads it, so it is read
  // directly once the synchronised clock shows that edge
  esp_sync #(.WIDTH(`ESP_SYNC_WIDTH)) u_pin_sync (
    .clk_in(clk_in),
    .d_in({chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in,
           por_ok_in, write_protect_input_in, sda_in, scl_in}),
    .q_out(pin_s)
  );

  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign wp_s = pin_s[2];
  assign por_s = pin_s[3];
  assign cs_s = pin_s[6:4];

  // previous values for edge detection; reset to the idle high level so
  // that leaving reset shows neither a false bit nor a false stop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // bus conditions and configuration
  assign sys_rst = rst_in || !por_s;
  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
  assign scl_fall = scl_d && !scl_s;
  // one bit per rising serial clock, seen through the synchroniser
  assign bit_ev = scl_s && !scl_d;
  assign active = (state != esp_pkg::ESP_ST_IDLE) && (state != esp_pkg::ESP_ST_IGNORE);
  assign rx_byte = {shift[6:0], link_bit};
  assign cs_expect = CS_PINS_PRESENT ? (cs_s & CS_PIN_USED) : `ESP_FIXED_CS;
  assign wp_eff = WP_PIN_USED && wp_s;
  assign byte_done = bit_ev && active && (bit_cnt == `ESP_LAST_DATA_BIT);
  assign ack_slot = bit_ev && active && (bit_cnt == `ESP_ACK_SLOT);

  // acknowledge decision for the byte now completing
  // a select mismatch drops to the ignore state until the next start
  always_comb begin
    next_ack = 1'b0;
    next_after = state;
    case (state)
      esp_pkg::ESP_ST_SEL: begin
        if (sel_match(rx_byte, cs_expect)) begin
          next_ack = 1'b1;
          next_after = (rx_byte[0] == `ESP_RW_READ) ?
                       esp_pkg::ESP_ST_READ : esp_pkg::ESP_ST_ADDR_HI;
        end else begin
          next_after = esp_pkg::ESP_ST_IGNORE;
        end
      end
      esp_pkg::ESP_ST_ADDR_HI: begin
        next_ack = 1'b1;
        next_after = esp_pkg::ESP_ST_ADDR_LO;
      end
      esp_pkg::ESP_ST_ADDR_LO: begin
        next_ack = 1'b1;
        next_after = esp_pkg::ESP_ST_DATA;
      end
      esp_pkg::ESP_ST_DATA: begin
        // a full buffer also refuses the byte, so the master sees back-pressure
        next_ack = !wp_eff && fifo_ready && !(id_sel && id_locked_in);
        next_after = esp_pkg::ESP_ST_DATA;
      end
      default: begin
        next_ack = 1'b0;
      end
    endcase
  end

  // data byte goes to the buffer only when it will be acknowledged
  assign push = byte_done && !start_ev && !stop_ev && !write_busy_in &&
                (state == esp_pkg::ESP_ST_DATA) && next_ack;

  // state and bit framing
  // an internal write holds the engine idle, so requests go unanswered
  always_ff @(posedge clk_in) begin
    if (sys_rst || write_busy_in) begin
      state <= esp_pkg::ESP_ST_IDLE;
      after_state <= esp_pkg::ESP_ST_IDLE;
      bit_cnt <= 4'h0;
      ack_drive <= 1'b0;
      shift <= 8'h00;
    end else if (start_ev) begin
      state <= esp_pkg::ESP_ST_SEL;
      bit_cnt <= 4'h0;
      ack_drive <= 1'b0;
    end else if (stop_ev) begin
      state <= esp_pkg::ESP_ST_IDLE;
      bit_cnt <= 4'h0;
      ack_drive <= 1'b0;
    end else if (ack_slot) begin
      bit_cnt <= 4'h0;
      ack_drive <= 1'b0;
      if (state == esp_pkg::ESP_ST_READ) begin
        // master's own acknowledge decides whether reading goes on
        state <= link_bit ? esp_pkg::ESP_ST_IGNORE : esp_pkg::ESP_ST_READ;
      end else begin
        state <= after_state;
      end
    end else if (bit_ev && active) begin
      shift <= rx_byte;
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == `ESP_LAST_DATA_BIT && state != esp_pkg::ESP_ST_READ) begin
        ack_drive <= next_ack;
        after_state <= next_after;
        if (next_after == esp_pkg::ESP_ST_IGNORE) begin
          state <= esp_pkg::ESP_ST_IGNORE;
        end
      end
    end
  end

  // remember which type was selected
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      id_sel <= 1'b0;
    end else if (byte_done && state == esp_pkg::ESP_ST_SEL) begin
      id_sel <= HAS_ID_PAGE && (rx_byte[7:4] == ID_TYPE_ID);
    end
  end

  // address bytes, high byte first
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      addr_out <= 16'h0000;
    end else if (byte_done && !start_ev && !stop_ev) begin
      if (state == esp_pkg::ESP_ST_ADDR_HI) begin
        addr_out[15:8] <= rx_byte;
      end else if (state == esp_pkg::ESP_ST_ADDR_LO) begin
        addr_out[7:0] <= rx_byte;
      end else if (state == esp_pkg::ESP_ST_DATA && id_sel) begin
        addr_out <= addr_out & `ESP_ID_ADDR_MASK;
      end
    end
  end

  // whether the last finished slot was an acknowledged data byte
  always_ff @(posedge clk_in) begin
    if (sys_rst || write_busy_in || start_ev) begin
      data_acked <= 1'b0;
    end else if (ack_slot) begin
      data_acked <= (state == esp_pkg::ESP_ST_DATA) && ack_drive;
    end else if (bit_ev && bit_cnt != 4'h0) begin
      // kept through the first rise after the acknowledge, which a stop uses
      data_acked <= 1'b0;
    end
  end

  // write cycle request on a stop right after a data acknowledge; the
  // stop's clock rise counts as the first bit of the tenth slot, so a
  // stop in any later slot finds the count past one and starts nothing
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      write_start_out <= 1'b0;
    end else begin
      write_start_out <= stop_ev && !write_busy_in && data_acked && !wp_eff &&
                         (state == esp_pkg::ESP_ST_DATA) && (bit_cnt == `ESP_STOP_SLOT);
    end
  end

  // transmit shift register and read advance pulse
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      tx <= 8'hff;
      rd_next_out <= 1'b0;
    end else begin
      rd_next_out <= 1'b0;
      if (ack_slot && state == esp_pkg::ESP_ST_SEL && after_state == esp_pkg::ESP_ST_READ) begin
        tx <= rd_data_in;
      end else if (ack_slot && state == esp_pkg::ESP_ST_READ && !link_bit) begin
        tx <= rd_data_in;
        rd_next_out <= 1'b1;
      end else if (bit_ev && state == esp_pkg::ESP_ST_READ && !ack_slot) begin
        tx <= {tx[6:0], 1'b1};
      end
    end
  end

  // open-drain data line: only the enable moves, changed while clock is low
  always_ff @(posedge clk_in) begin
    if (sys_rst || write_busy_in || start_ev || stop_ev) begin
      sda_oe_out <= 1'b0;
    end else if (scl_fall) begin
      if (state == esp_pkg::ESP_ST_READ && bit_cnt != `ESP_ACK_SLOT) begin
        sda_oe_out <= !tx[7];
      end else if (bit_cnt == `ESP_ACK_SLOT) begin
        sda_oe_out <= ack_drive && state != esp_pkg::ESP_ST_READ;
      end else begin
        sda_oe_out <= 1'b0;
      end
    end
  end

  // driven level is always low; a high comes only from the pull-up
  always_ff @(posedge clk_in) begin
    sda_out <= 1'b0;
  end

  // standby whenever not in a transfer and no write cycle runs
  // a deselected device drops back here at once, not at the next stop
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      standby_out <= 1'b1;
    end else begin
      standby_out <= !active && !write_busy_in;
    end
  end

  // buffer between the bus and the memory write port
  esp_fifo #(.WIDTH(`ESP_FIFO_WIDTH), .DEPTH(`ESP_FIFO_DEPTH)) u_wr_fifo (
    .clk_in(clk_in),
    .rst_in(sys_rst),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in({id_sel, rx_byte}),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(fifo_out)
  );

  assign wr_data_out = fifo_out[7:0];
  assign wr_id_page_out = fifo_out[8];

endmodule
`default_nettype wire

// [testbench/esp_slave_assertions.sv]
// concurrent checks on the ports of the serial memory slave front end
`timescale 1ns/100ps
`default_nettype none
module esp_slave_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic write_protect_input_in,
  input wire logic por_ok_in,
  input wire logic write_busy_in,
  input wire logic rd_next_out,
  input wire logic wr_valid_out,
  input wire logic wr_ready_in,
  input wire logic [7:0] wr_data_out,
  input wire logic wr_id_page_out,
  input wire logic write_start_out,
  input wire logic standby_out
);
  // everything is sampled in the system clock domain
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  drive_low_a: assert property (sda_oe_out |-> sda_out == 1'h0)
    else $error("data line driven high");
  busy_quiet_a: assert property (write_busy_in [*4] |-> !sda_oe_out)
    else $error("data line active during internal write");
  // sync depth plus state update fits well inside six cycles
  power_low_a: assert property (!por_ok_in [*6] |-> standby_out && !sda_oe_out)
    else $error("device active below supply threshold");
  start_pulse_a: assert property (write_start_out |=> !write_start_out)
    else $error("write start longer than one cycle");
  next_pulse_a: assert property (rd_next_out |=> !rd_next_out)
    else $error("read advance longer than one cycle");
  head_hold_a: assert property (wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable(wr_data_out) && $stable(wr_id_page_out))
    else $error("buffer head changed while not taken");
  protect_write_a: assert property (write_protect_input_in [*8] |->
    !write_start_out && !$rose(wr_valid_out))
    else $error("data accepted while protected");
  ack_low_a: assert property ($rose(sda_oe_out) |-> !scl_in ##1 sda_oe_out [*4])
    else $error("acknowledge not held through its slot");
  // the slave may only move the line while the serial clock is low
  oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line changed while serial clock high");
endmodule
bind esp_slave esp_slave_assertions u_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .write_protect_input_in(write_protect_input_in),
  .por_ok_in(por_ok_in),
  .write_busy_in(write_busy_in),
  .rd_next_out(rd_next_out),
  .wr_valid_out(wr_valid_out),
  .wr_ready_in(wr_ready_in),
  .wr_data_out(wr_data_out),
  .wr_id_page_out(wr_id_page_out),
  .write_start_out(write_start_out),
  .standby_out(standby_out)
);
`default_nettype wire

// [testbench/esp_master_model.sv]
// behavioural two-wire bus master driving clock and data
`timescale 1ns/100ps
`default_nettype none
module esp_master_model (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in
);
  // clock stands high between frames; quarter slot of 30 ns
  initial begin
    scl_out = 1'h1;
    sda_oe_out = 1'h0;
  end

  // start or repeated start: data falls while clock high
  task automatic start();
    #30 sda_oe_out = 1'h0;
    #30 scl_out = 1'h1;
    #60 sda_oe_out = 1'h1;
    #60 scl_out = 1'h0;
  endtask

  // one slot: data changes in clock low, sampled in clock high
  task automatic bit_slot(input logic b, output logic s);
    #30 sda_oe_out = !b;
    #30 scl_out = 1'h1;
    #30 s = sda_in;
    #30 scl_out = 1'h0;
  endtask

  // eight bits then the ninth slot released for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'h1, s);
    ack = !s;
  endtask

  // eight bits from the slave, then the master's own acknowledge slot
  task automatic read_byte(input logic ack_in, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'h1, s);
      d[i] = s;
    end
    bit_slot(!ack_in, s);
  endtask

  // stop: data rises while clock high, then the bus idles
  task automatic stop();
    #30 sda_oe_out = 1'h1;
    #30 scl_out = 1'h1;
    #60 sda_oe_out = 1'h0;
    #60;
  endtask
endmodule
`default_nettype wire

// [testbench/eeprom_serial_slave_select_protect_tb.sv]
// self-checking bench for the serial memory slave front end
`timescale 1ns/100ps
`default_nettype none
module eeprom_serial_slave_select_protect_tb;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [2:0] cs = 3'h0;
  logic wp = 1'h0, por_ok = 1'h1, busy = 1'h0, wr_ready = 1'h0;
  logic sda_out, sda_oe_out, rd_next, wr_valid, wr_id, wstart, standby, a;
  logic [7:0] wr_data, d, rd_data = 8'h5a;
  logic [15:0] addr;
  wire scl, m_oe, sda_wire;
  int mismatches = 0, check_count = 0, starts = 0, reads = 0, n, cnt;
  // select table: pins, select byte, acknowledge expected
  logic [11:0] rows [6] = '{{3'h5, 8'h3a, 1'h1}, {3'h5, 8'h38, 1'h0}, {3'h2, 8'h34, 1'h1},
    {3'h2, 8'h54, 1'h0}, {3'h7, 8'h3e, 1'h1}, {3'h0, 8'h30, 1'h1}};

  // open-drain wire with pull-up: low if anyone pulls
  assign sda_wire = !(m_oe || (sda_oe_out && !sda_out));

  esp_master_model master (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda_wire));
  esp_slave dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .chip_select_bit2_in(cs[2]),
    .chip_select_bit1_in(cs[1]), .chip_select_bit0_in(cs[0]),
    .write_protect_input_in(wp), .por_ok_in(por_ok), .write_busy_in(busy),
    .id_locked_in(1'h0), .rd_data_in(rd_data), .rd_next_out(rd_next),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_data_out(wr_data),
    .wr_id_page_out(wr_id), .addr_out(addr), .write_start_out(wstart),
    .standby_out(standby));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // count internal write starts and read advances
  always @(posedge clk_in) begin
    if (wstart === 1'h1) starts <= starts + 1;
    if (rd_next === 1'h1) reads <= reads + 1;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic frame(input logic [7:0] sel, output logic ack);
    @(negedge clk_in);
    master.start();
    master.send_byte(sel, ack);
  endtask

  task automatic end_frame();
    master.stop();
    repeat (8) @(negedge clk_in);
  endtask

  // select, two address bytes, then n data bytes; returns data acks
  task automatic write_seq(input logic [7:0] sel, input int cnt_in, output int acks);
    logic k;
    acks = 0;
    frame(sel, k);
    check("select ack", 16'h1, k);
    master.send_byte(8'h12, k);
    check("addr hi ack", 16'h1, k);
    master.send_byte(8'h34, k);
    check("addr lo ack", 16'h1, k);
    for (int i = 0; i < cnt_in; i++) begin
      master.send_byte(8'ha0 + i[7:0], k);
      if (k === 1'h1) acks++;
    end
  endtask

  // watchdog: the whole run needs well under 200 us
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (4) @(negedge clk_in);
    check("reset standby", 16'h1, standby);
    check("reset oe", 16'h0, sda_oe_out);
    check("reset valid", 16'h0, wr_valid);
    check("reset addr", 16'h0, addr);
    rst_in = 1'h0;
    repeat (4) @(negedge clk_in);
    $display("test reset done");
    foreach (rows[i]) begin
      cs = rows[i][11:9];
      repeat (4) @(negedge clk_in);
      frame(rows[i][8:1], a);
      check("select ack", 16'(rows[i][0]), a);
      master.send_byte({4'h3, rows[i][11:9], 1'h0}, a);
      check("second byte ack", 16'(rows[i][0]), a);
      end_frame();
      check("standby after stop", 16'h1, standby);
    end
    check("no write without data", 16'h0, starts[15:0]);
    $display("test select table done");
    cs = 3'h5;
    repeat (4) @(negedge clk_in);
    write_seq(8'h3a, 1, n);
    check("data ack", 16'h1, n[15:0]);
    check("head valid", 16'h1, wr_valid);
    check("head data", 16'h00a0, wr_data);
    check("address", 16'h1234, addr);
    check("id flag", 16'h0, wr_id);
    end_frame();
    check("write started", 16'h1, starts[15:0]);
    wr_ready = 1'h1;
    @(negedge clk_in);
    wr_ready = 1'h0;
    check("drained", 16'h0, wr_valid);
    write_seq(8'h4a, 1, n);
    check("id flag", 16'h1, wr_id);
    check("id address", 16'h0014, addr);
    end_frame();
    wr_ready = 1'h1;
    @(negedge clk_in);
    wr_ready = 1'h0;
    $display("test write done");
    wp = 1'h1;
    repeat (4) @(negedge clk_in);
    write_seq(8'h3a, 2, n);
    check("protected data acks", 16'h0, n[15:0]);
    check("protected push", 16'h0, wr_valid);
    end_frame();
    check("protected no write", 16'h2, starts[15:0]);
    wp = 1'h0;
    repeat (4) @(negedge clk_in);
    $display("test protect done");
    write_seq(8'h3a, 10, n);
    check("refused when full", 16'h1, 16'(n >= 8 && n < 10));
    check("oldest first", 16'h00a0, wr_data);
    end_frame();
    cnt = 0;
    wr_ready = 1'h1;
    repeat (20) begin
      if (wr_valid === 1'h1) cnt++;
      @(negedge clk_in);
    end
    wr_ready = 1'h0;
    check("drained count", n[15:0], cnt[15:0]);
    $display("test buffer done");
    frame(8'h3b, a);
    check("read select ack", 16'h1, a);
    master.read_byte(1'h1, d);
    check("read byte", 16'h005a, d);
    master.read_byte(1'h0, d);
    check("read second byte", 16'h005a, d);
    end_frame();
    check("read advances", 16'h1, reads[15:0]);
    $display("test read done");
    busy = 1'h1;
    frame(8'h3a, a);
    check("busy select", 16'h0, a);
    end_frame();
    busy = 1'h0;
    por_ok = 1'h0;
    repeat (6) @(negedge clk_in);
    check("low supply standby", 16'h1, standby);
    frame(8'h3a, a);
    check("low supply select", 16'h0, a);
    end_frame();
    por_ok = 1'h1;
    repeat (4) @(negedge clk_in);
    frame(8'h3a, a);
    check("supply back select", 16'h1, a);
    end_frame();
    $display("test power done");
    finish_test();
  end
endmodule
`default_nettype wire
